/* hdl/lpc_io_window_irq_routing.sv */
// lpc i/o window decode, sticky interrupt status and serial irq routing
// assumes the register port carries lpc i/o cycles only, one byte each,
// and that lpc clock, serial irq and platform reset arrive as raw pins
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - interrupts reach the host only over the serial irq stream
// - each source has an enable and a line select among irq3..irq11
// - sources: three timer bits, eight gpio bits, two uarts, watchdog
// - several sources on one line are ored together
// - non-uart status bits are sticky and cleared by writing one
// - uart interrupts pass straight through, never latched
// - an enabled slot is driven in every frame
// - slots are active high: low when idle, high when pending
// - only i/o cycles inside one 64-byte window are answered
// - all accesses are byte wide; word halves arrive as two cycles
// - addresses 0x1c80 to 0x1cbf are decoded, others ignored
// - last four bytes of the window go to the counter-timer
// - the timer sub-window starts on a four-byte boundary
// - reserved bits and locations read zero and ignore writes
// - clear-on-read fields return their value then reset to zero, except for losses seen in the read cycle
// - power-on domain registers reset only at power-on
// - platform domain registers reset at every platform reset
// - selectable domain follows platform reset unless aux hold is set
// - read-only status has no reset value and reflects live state
module lpc_io_window_irq_routing #(
	parameter int GPIO_COUNT = 8,
	parameter int TIMER_BITS = 3
) (
	input  wire logic                      core_clk,
	input  wire logic                      rst_n,
	input  wire logic                      platform_rst_pin_n,
	input  wire lpc_window_pkg::reg_req_t  reg_req,
	output logic [7:0]                     reg_rdata,
	output lpc_window_pkg::tmr_req_t       tmr_req,
	input  wire logic [7:0]                tmr_rdata,
	input  wire logic [TIMER_BITS-1:0]     timer_event,
	input  wire logic                      wdog_event,
	input  wire logic [1:0]                uart_irq,
	input  wire logic [GPIO_COUNT-1:0]     gpio_pin,
	input  wire logic                      lpc_clk_pin,
	input  wire logic                      serirq_in,
	output logic                           serirq_out,
	output logic                           serirq_oe_n
);

	// maps a 3-bit line select onto the slot number on the stream
	function automatic logic [3:0] line_of(input logic [2:0] sel);
		case (sel)
			3'h0:    line_of = 4'h3;
			3'h1:    line_of = 4'h4;
			3'h2:    line_of = 4'h5;
			3'h3:    line_of = 4'h6;
			3'h4:    line_of = 4'h7;
			3'h5:    line_of = 4'h9;
			3'h6:    line_of = 4'ha;
			default: line_of = 4'hb;
		endcase
	endfunction : line_of

	// pulls the routing fields out of a control byte
	function automatic lpc_window_pkg::route_t route_of(input logic [7:0] r);
		route_of.en  = r[lpc_window_pkg::ROUTE_EN_BIT];
		route_of.sel = r[lpc_window_pkg::ROUTE_SEL_LSB +: 3];
	endfunction : route_of

	// pin synchronisers: first stage feeds only the second
	logic [1:0]            plat_sync;
	logic [2:0]            lclk_sync;
	logic [1:0]            sirq_sync;
	logic [GPIO_COUNT-1:0] gpio_meta;
	logic [GPIO_COUNT-1:0] gpio_live;
	logic [GPIO_COUNT-1:0] gpio_prev;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			plat_sync <= 2'h0;
			lclk_sync <= 3'h0;
			sirq_sync <= 2'h3;
		end else begin
			plat_sync <= {plat_sync[0], platform_rst_pin_n};
			lclk_sync <= {lclk_sync[1:0], lpc_clk_pin};
			sirq_sync <= {sirq_sync[0], serirq_in};
		end
	end

	// gpio samples carry no reset: they only mirror the pins
	always_ff @(posedge core_clk) begin
		gpio_meta <= gpio_pin;
		gpio_live <= gpio_meta;
		gpio_prev <= gpio_live;
	end

	// platform reset held high while the synced pin is low
	logic plat_rst;
	logic lclk_rise;
	assign plat_rst  = !plat_sync[1];
	assign lclk_rise = lclk_sync[1] && !lclk_sync[2];

	// address decode of the host byte access
	logic       in_window;
	logic [5:0] offset;
	logic       wr_hit;
	logic       rd_hit;
	logic       tmr_hit;

	assign in_window = (reg_req.addr >= lpc_window_pkg::WINDOW_BASE) &&
	                   (reg_req.addr <= lpc_window_pkg::WINDOW_LAST);
	assign offset    = reg_req.addr[5:0];
	assign wr_hit    = reg_req.wr && in_window;
	assign rd_hit    = reg_req.rd && in_window;
	// base is a multiple of four so the low two bits index the timer
	assign tmr_hit   = offset[5:2] == lpc_window_pkg::TIMER_SUB_BASE[5:2];

	// power-on domain: aux hold select survives platform resets
	logic aux_power_hold_select;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aux_power_hold_select <= lpc_window_pkg::AUX_RESET;
		end else if (wr_hit && offset == lpc_window_pkg::OFF_MISC_POWER) begin
			aux_power_hold_select <= reg_req.wdata[lpc_window_pkg::POWER_AUX_BIT];
		end
	end

	// the selectable domain drops out of platform reset once aux hold is set
	logic selectable_reset_domain;
	assign selectable_reset_domain = plat_rst && !aux_power_hold_select;

	// platform domain control bytes
	logic [7:0] timer_ctrl;
	logic [7:0] wdog_ctrl;
	logic [7:0] uart1_route;
	logic [7:0] uart2_route;
	logic [7:0] gpio_mask;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_ctrl  <= lpc_window_pkg::ROUTE_RESET;
			wdog_ctrl   <= lpc_window_pkg::ROUTE_RESET;
			uart1_route <= lpc_window_pkg::ROUTE_RESET;
			uart2_route <= lpc_window_pkg::ROUTE_RESET;
			gpio_mask   <= lpc_window_pkg::MASK_RESET;
		end else if (plat_rst) begin
			timer_ctrl  <= lpc_window_pkg::ROUTE_RESET;
			wdog_ctrl   <= lpc_window_pkg::ROUTE_RESET;
			uart1_route <= lpc_window_pkg::ROUTE_RESET;
			uart2_route <= lpc_window_pkg::ROUTE_RESET;
			gpio_mask   <= lpc_window_pkg::MASK_RESET;
		end else if (wr_hit) begin
			// bit 3 of the routing bytes is reserved and stays zero
			case (offset)
				lpc_window_pkg::OFF_TIMER_CTRL:  timer_ctrl  <= reg_req.wdata & 8'hf7;
				lpc_window_pkg::OFF_WDOG_CTRL:   wdog_ctrl   <= reg_req.wdata & 8'hf1;
				lpc_window_pkg::OFF_UART1_ROUTE: uart1_route <= reg_req.wdata & 8'hf0;
				lpc_window_pkg::OFF_UART2_ROUTE: uart2_route <= reg_req.wdata & 8'hf0;
				lpc_window_pkg::OFF_GPIO_MASK:   gpio_mask   <= reg_req.wdata;
				default: ;
			endcase
		end
	end

	// selectable domain: gpio routing may keep its setting across sleep
	logic [7:0] gpio_route;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gpio_route <= lpc_window_pkg::ROUTE_RESET;
		end else if (selectable_reset_domain) begin
			gpio_route <= lpc_window_pkg::ROUTE_RESET;
		end else if (wr_hit && offset == lpc_window_pkg::OFF_GPIO_ROUTE) begin
			gpio_route <= reg_req.wdata & 8'hf0;
		end
	end

	// sticky status with write-one clear; a same-cycle event wins
	logic [TIMER_BITS-1:0] timer_stat;
	logic                  wdog_stat;
	logic [GPIO_COUNT-1:0] gpio_stat;
	logic [TIMER_BITS-1:0] timer_clr;
	logic                  wdog_clr;
	logic [GPIO_COUNT-1:0] gpio_clr;
	logic [GPIO_COUNT-1:0] gpio_event;

	assign timer_clr  = (wr_hit && offset == lpc_window_pkg::OFF_TIMER_STAT) ?
	                    reg_req.wdata[TIMER_BITS-1:0] : '0;
	assign wdog_clr   = wr_hit && offset == lpc_window_pkg::OFF_WDOG_STAT &&
	                    reg_req.wdata[0];
	assign gpio_clr   = (wr_hit && offset == lpc_window_pkg::OFF_GPIO_STAT) ?
	                    reg_req.wdata[GPIO_COUNT-1:0] : '0;
	assign gpio_event = gpio_live & ~gpio_prev; // rising edge of a synced pin

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_stat <= '0;
			wdog_stat  <= 1'b0;
			gpio_stat  <= '0;
		end else if (plat_rst) begin
			timer_stat <= '0;
			wdog_stat  <= 1'b0;
			gpio_stat  <= '0;
		end else begin
			timer_stat <= (timer_stat & ~timer_clr) | timer_event;
			wdog_stat  <= (wdog_stat & ~wdog_clr) | wdog_event;
			gpio_stat  <= (gpio_stat & ~gpio_clr) | gpio_event;
		end
	end

	// lost-event flags: an event hitting an already set bit; read clears
	logic [7:0] lost_events;
	logic [7:0] lost_now;
	logic       lost_read;

	assign lost_now  = {4'h0, |(gpio_stat & gpio_event), wdog_stat & wdog_event,
	                    |(timer_stat & timer_event), 1'b0};
	assign lost_read = rd_hit && offset == lpc_window_pkg::OFF_LOST_EVENTS;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lost_events <= lpc_window_pkg::STAT_RESET;
		end else if (plat_rst) begin
			lost_events <= lpc_window_pkg::STAT_RESET;
		end else if (lost_read) begin
			lost_events <= lost_now; // new losses survive the read
		end else begin
			lost_events <= lost_events | lost_now;
		end
	end

	// read mux; read data stands only in the cycle after the strobe
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = 8'h00; // unmapped and reserved read zero
		if (tmr_hit) begin
			next_rdata = tmr_rdata;
		end else begin
			case (offset)
				lpc_window_pkg::OFF_TIMER_CTRL:  next_rdata = timer_ctrl;
				lpc_window_pkg::OFF_TIMER_STAT:  next_rdata = 8'(timer_stat);
				lpc_window_pkg::OFF_MISC_POWER:
					next_rdata = 8'(aux_power_hold_select) << lpc_window_pkg::POWER_AUX_BIT;
				lpc_window_pkg::OFF_WDOG_CTRL:   next_rdata = wdog_ctrl;
				lpc_window_pkg::OFF_WDOG_STAT:   next_rdata = {7'h00, wdog_stat};
				lpc_window_pkg::OFF_UART1_ROUTE: next_rdata = uart1_route;
				lpc_window_pkg::OFF_UART2_ROUTE: next_rdata = uart2_route;
				lpc_window_pkg::OFF_GPIO_ROUTE:  next_rdata = gpio_route;
				lpc_window_pkg::OFF_LOST_EVENTS: next_rdata = lost_events;
				lpc_window_pkg::OFF_GPIO_IN:     next_rdata = 8'(gpio_live);
				lpc_window_pkg::OFF_GPIO_MASK:   next_rdata = gpio_mask;
				lpc_window_pkg::OFF_GPIO_STAT:   next_rdata = 8'(gpio_stat);
				default:                         next_rdata = 8'h00;
			endcase
		end
	end

	// out-of-window reads return zero as well, so nothing floats
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (rd_hit) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// timer sub-window access forwarded as a registered request
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr_req <= '0;
		end else begin
			tmr_req.addr  <= offset[1:0];
			tmr_req.wdata <= reg_req.wdata;
			tmr_req.wr    <= wr_hit && tmr_hit;
			tmr_req.rd    <= rd_hit && tmr_hit;
		end
	end

	// per-line request and drive vectors, ored over all sources
	logic [15:0] slot_drive;
	logic [15:0] slot_level;
	logic [TIMER_BITS-1:0] timer_mask;
	lpc_window_pkg::route_t r_tmr;
	lpc_window_pkg::route_t r_wdg;
	lpc_window_pkg::route_t r_u1;
	lpc_window_pkg::route_t r_u2;
	lpc_window_pkg::route_t r_gpio;

	assign timer_mask = timer_ctrl[TIMER_BITS-1:0];
	assign r_tmr  = route_of(timer_ctrl);
	assign r_wdg  = route_of(wdog_ctrl);
	assign r_u1   = route_of(uart1_route);
	assign r_u2   = route_of(uart2_route);
	assign r_gpio = route_of(gpio_route);

	genvar line;
	generate
		for (line = 0; line < 16; line++) begin : g_line
			logic t_on, w_on, a_on, b_on, g_on;
			assign t_on = r_tmr.en  && line_of(r_tmr.sel)  == 4'(line);
			assign w_on = r_wdg.en  && line_of(r_wdg.sel)  == 4'(line);
			assign a_on = r_u1.en   && line_of(r_u1.sel)   == 4'(line);
			assign b_on = r_u2.en   && line_of(r_u2.sel)   == 4'(line);
			assign g_on = r_gpio.en && line_of(r_gpio.sel) == 4'(line);
			// any enabled source claims the slot, even while quiet
			assign slot_drive[line] = t_on || w_on || a_on || b_on || g_on;
			assign slot_level[line] =
				(t_on && |(timer_stat & timer_mask)) ||
				(w_on && wdog_stat && wdog_ctrl[0]) ||
				(a_on && uart_irq[0]) ||
				(b_on && uart_irq[1]) ||
				(g_on && |(gpio_stat & gpio_mask));
		end
	endgenerate

	// serial irq frame follower, stepped on each lpc clock rising edge
	typedef enum logic [1:0] {
		SIRQ_IDLE,
		SIRQ_START,
		SIRQ_TAIL,
		SIRQ_SLOT
	} sirq_state_t;

	sirq_state_t sirq_state;
	logic [3:0]  tail_cnt;
	logic [4:0]  slot_idx;
	logic [1:0]  phase;

	// the host opens each frame; the device only answers its slots
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sirq_state <= SIRQ_IDLE;
			tail_cnt   <= 4'h0;
			slot_idx   <= 5'h00;
			phase      <= 2'h0;
		end else if (plat_rst) begin
			sirq_state <= SIRQ_IDLE;
		end else if (lclk_rise) begin
			case (sirq_state)
				SIRQ_IDLE: begin
					if (!sirq_sync[1]) begin
						sirq_state <= SIRQ_START;
					end
				end
				SIRQ_START: begin
					if (sirq_sync[1]) begin
						sirq_state <= SIRQ_TAIL;
						tail_cnt   <= 4'h1;
					end
				end
				SIRQ_TAIL: begin
					if (tail_cnt == lpc_window_pkg::SIRQ_TAIL_CLKS) begin
						sirq_state <= SIRQ_SLOT;
						slot_idx   <= 5'h00;
						phase      <= 2'h0;
					end else begin
						tail_cnt <= tail_cnt + 4'h1;
					end
				end
				SIRQ_SLOT: begin
					if (phase == lpc_window_pkg::SIRQ_SLOT_CLKS - 2'h1) begin
						phase <= 2'h0;
						if (slot_idx == lpc_window_pkg::SIRQ_SLOTS - 5'h01) begin
							sirq_state <= SIRQ_IDLE;
						end else begin
							slot_idx <= slot_idx + 5'h01;
						end
					end else begin
						phase <= phase + 2'h1;
					end
				end
				default: sirq_state <= SIRQ_IDLE;
			endcase
		end
	end

	// drive only in the sample phase of an enabled slot, released otherwise
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			serirq_oe_n <= 1'b1;
			serirq_out  <= 1'b0;
		end else if (sirq_state == SIRQ_SLOT && phase == 2'h0 &&
		             slot_drive[slot_idx[3:0]]) begin
			serirq_oe_n <= 1'b0;
			serirq_out  <= slot_level[slot_idx[3:0]];
		end else begin
			serirq_oe_n <= 1'b1;
			serirq_out  <= 1'b0;
		end
	end

endmodule : lpc_io_window_irq_routing

`default_nettype wire

/* hdl/lpc_window_pkg.sv */
// constants and carrier types for the lpc i/o window and interrupt router
// assumes a byte-wide register port already qualified as lpc i/o cycles
`default_nettype none
package lpc_window_pkg;

	// i/o window
	localparam logic [15:0] WINDOW_BASE     = 16'h1c80;
	localparam logic [15:0] WINDOW_LAST     = 16'h1cbf;
	localparam logic [5:0]  TIMER_SUB_BASE  = 6'h3c;

	// register offsets inside the window
	localparam logic [5:0] OFF_TIMER_CTRL   = 6'h03;
	localparam logic [5:0] OFF_TIMER_STAT   = 6'h04;
	localparam logic [5:0] OFF_MISC_POWER   = 6'h10;
	localparam logic [5:0] OFF_WDOG_CTRL    = 6'h13;
	localparam logic [5:0] OFF_WDOG_STAT    = 6'h14;
	localparam logic [5:0] OFF_UART1_ROUTE  = 6'h15;
	localparam logic [5:0] OFF_UART2_ROUTE  = 6'h16;
	localparam logic [5:0] OFF_GPIO_ROUTE   = 6'h17;
	localparam logic [5:0] OFF_LOST_EVENTS  = 6'h18;
	localparam logic [5:0] OFF_GPIO_IN      = 6'h24;
	localparam logic [5:0] OFF_GPIO_MASK    = 6'h25;
	localparam logic [5:0] OFF_GPIO_STAT    = 6'h26;

	// field positions: routing byte enable and select, aux hold bit of the power byte
	localparam int ROUTE_EN_BIT  = 7;
	localparam int ROUTE_SEL_LSB = 4;
	localparam int POWER_AUX_BIT = 1;

	// reset values
	localparam logic [7:0] ROUTE_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET  = 8'h00;
	localparam logic [7:0] STAT_RESET  = 8'h00;
	localparam logic       AUX_RESET   = 1'b0;

	// serial interrupt framing, in lpc clock periods
	localparam logic [3:0] SIRQ_TAIL_CLKS  = 4'h2;
	localparam logic [1:0] SIRQ_SLOT_CLKS  = 2'h3;
	localparam logic [4:0] SIRQ_SLOTS      = 5'h10;

	// one register access from the host
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	// access forwarded to the counter-timer sub-window
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tmr_req_t;

	// one source's routing: enable and line select
	typedef struct packed {
		logic       en;
		logic [2:0] sel;
	} route_t;

endpackage : lpc_window_pkg

`default_nettype wire

/* sim/lpc_io_window_irq_routing_checker.sv */
// checks on window decode, timer forwarding and status clearing
// assumes one clock domain; bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module lpc_io_window_irq_routing_checker #(
	parameter int GPIO_COUNT = 8,
	parameter int TIMER_BITS = 3
) (
	input wire logic                     core_clk,
	input wire logic                     rst_n,
	input wire lpc_window_pkg::reg_req_t reg_req,
	input wire logic [7:0]               reg_rdata,
	input wire lpc_window_pkg::tmr_req_t tmr_req,
	input wire logic [7:0]               tmr_rdata,
	input wire logic [TIMER_BITS-1:0]    timer_event
);
	logic       in_win;
	logic       in_tmr;
	logic       acc;
	logic       w_stat;
	logic       r_stat;
	logic [1:0] sub;

	// decode helpers; the timer sub-window is the top four bytes
	assign in_win = reg_req.addr >= lpc_window_pkg::WINDOW_BASE
		&& reg_req.addr <= lpc_window_pkg::WINDOW_LAST;
	assign in_tmr = in_win && reg_req.addr[5:0] >= lpc_window_pkg::TIMER_SUB_BASE;
	assign acc = reg_req.wr || reg_req.rd;
	assign w_stat = reg_req.wr && in_win && reg_req.addr[5:0] == lpc_window_pkg::OFF_TIMER_STAT;
	assign r_stat = reg_req.rd && in_win && reg_req.addr[5:0] == lpc_window_pkg::OFF_TIMER_STAT;
	assign sub = reg_req.addr[1:0];

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_outside_reads_zero: assert property (reg_req.rd && !in_win |=> reg_rdata == 8'h00)
		else $error("read outside the window returned data");
	a_timer_forward: assert property (acc && in_tmr |=> tmr_req.wr == $past(reg_req.wr)
		&& tmr_req.rd == $past(reg_req.rd) && tmr_req.addr == $past(sub)
		&& tmr_req.wdata == $past(reg_req.wdata))
		else $error("timer access not forwarded one cycle later");
	a_timer_quiet: assert property (!(acc && in_tmr) |=> !tmr_req.wr && !tmr_req.rd)
		else $error("timer strobe without a sub-window access");
	a_timer_readback: assert property (reg_req.rd && in_tmr |=> reg_rdata == $past(tmr_rdata))
		else $error("timer read byte not returned");
	a_reserved_zero: assert property (reg_req.rd && in_win
		&& reg_req.addr[5:0] == 6'h06 |=> reg_rdata == 8'h00)
		else $error("reserved location read nonzero");
	a_route_low_bits: assert property (reg_req.rd && in_win
		&& reg_req.addr[5:0] == lpc_window_pkg::OFF_UART1_ROUTE |=> reg_rdata[3:0] == 4'h0)
		else $error("reserved routing bits read nonzero");
	a_clear_by_one: assert property ((w_stat && reg_req.wdata[0] && !timer_event[0])
		##1 (!timer_event[0] && !reg_req.wr) ##1 (r_stat && !timer_event[0]) |=> !reg_rdata[0])
		else $error("status bit survived a write of one");
	a_event_beats_clear: assert property ((w_stat && reg_req.wdata[0] && timer_event[0])
		##1 !reg_req.wr ##1 r_stat |=> reg_rdata[0])
		else $error("clear won over a same-cycle event");
endmodule : lpc_io_window_irq_routing_checker

bind lpc_io_window_irq_routing lpc_io_window_irq_routing_checker #(
	.GPIO_COUNT(GPIO_COUNT), .TIMER_BITS(TIMER_BITS)) checker_inst (.core_clk(core_clk),
	.rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .tmr_req(tmr_req),
	.tmr_rdata(tmr_rdata), .timer_event(timer_event));
`default_nettype wire

/* sim/serirq_host_model.sv */
// host end of the serial irq wire: free lpc clock, start pulse, slot sampling
// assumes the device drives the wire only while its enable is low
`timescale 1ns/1ps
`default_nettype none
module serirq_host_model (
	output logic      lpc_clk,
	output logic      serirq_level,
	input  wire logic serirq_out,
	input  wire logic serirq_oe_n
);
	logic host_low = 1'b0;
	logic clk_q = 1'b0;
	logic lvl [0:55];
	logic drv [0:55];

	// lpc clock runs free, 60 ns period
	always #30 clk_q = ~clk_q;
	assign lpc_clk = clk_q;

	// pulled-up wire: host start pulse wins, then device drive, else high
	assign serirq_level = host_low ? 1'b0 : (serirq_oe_n ? 1'b1 : serirq_out);

	// sample mid-period, clear of the device's synchroniser lag
	task run_frame;
		int i;
		@(posedge lpc_clk);
		host_low <= 1'b1;
		repeat (4) @(posedge lpc_clk);
		host_low <= 1'b0;
		for (i = 0; i < 56; i++) begin
			@(negedge lpc_clk);
			lvl[i] = serirq_level;
			drv[i] = !serirq_oe_n;
		end
	endtask : run_frame
endmodule : serirq_host_model
`default_nettype wire

/* sim/tb_lpc_io_window_irq_routing.sv */
// bench: byte register tasks, status sequences and serial irq frames
// assumes the host model owns the lpc clock and the irq wire
`timescale 1ns/1ps
`default_nettype none
module tb_lpc_io_window_irq_routing;
	logic                     core_clk = 1'b0;
	logic                     rst_n = 1'b0;
	logic                     plat_n = 1'b1;
	lpc_window_pkg::reg_req_t reg_req = '0;
	logic [7:0]               reg_rdata;
	lpc_window_pkg::tmr_req_t tmr_req;
	logic [7:0]               tmr_rdata = 8'h5a;
	logic [2:0]               timer_event = 3'h0;
	logic                     wdog_event = 1'b0;
	logic [1:0]               uart_irq = 2'h0;
	logic [7:0]               gpio_pin = 8'h00;
	logic                     lpc_clk;
	logic                     serirq_level;
	logic                     serirq_out;
	logic                     serirq_oe_n;
	int                       err_total = 0;
	int                       n_compared = 0;
	int                       base;
	int                       last_pos;
	int                       i;
	int                       irq_of [8] = '{3, 4, 5, 6, 7, 9, 10, 11};

	always #2.5 core_clk = ~core_clk;

	lpc_io_window_irq_routing lpc_io_window_irq_routing_inst (.core_clk(core_clk),
		.rst_n(rst_n), .platform_rst_pin_n(plat_n), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .tmr_req(tmr_req), .tmr_rdata(tmr_rdata),
		.timer_event(timer_event), .wdog_event(wdog_event), .uart_irq(uart_irq),
		.gpio_pin(gpio_pin), .lpc_clk_pin(lpc_clk), .serirq_in(serirq_level),
		.serirq_out(serirq_out), .serirq_oe_n(serirq_oe_n));
	serirq_host_model serirq_host_model_inst (.lpc_clk(lpc_clk),
		.serirq_level(serirq_level), .serirq_out(serirq_out), .serirq_oe_n(serirq_oe_n));

	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : check

	// one write; ev pulses {watchdog, timer} in the same cycle
	task wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] ev);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		{wdog_event, timer_event} <= ev;
		@(posedge core_clk);
		reg_req <= '0;
		{wdog_event, timer_event} <= 4'h0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		reg_req <= '0;
		#1 check(reg_rdata, exp);
	endtask : rd

	task plat_pulse;
		@(posedge core_clk);
		plat_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		plat_n <= 1'b1;
		repeat (6) @(posedge core_clk);
	endtask : plat_pulse

	// one frame; counts the periods the device drove and keeps the level
	task slot(input logic lvl, input int cnt);
		int k;
		int n;
		logic seen;
		n = 0;
		seen = 1'bx;
		serirq_host_model_inst.run_frame();
		for (k = 0; k < 56; k++) begin
			if (serirq_host_model_inst.drv[k] === 1'b1) begin
				n++;
				last_pos = k;
				seen = serirq_host_model_inst.lvl[k];
			end
		end
		check(8'(n), 8'(cnt));
		if (cnt > 0) check({7'h00, seen}, {7'h00, lvl});
	endtask : slot

	task report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	// a hang ends the run as a mismatch
	initial begin
		#200000;
		err_total++;
		report_and_stop();
	end

	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(16'h1c83, 8'h00);
		rd(16'h1c90, 8'h00);
		wr(16'h1c86, 8'hff, 4'h0);
		rd(16'h1c86, 8'h00);
		wr(16'h1c95, 8'hff, 4'h0);
		rd(16'h1c95, 8'hf0);
		wr(16'h1cc3, 8'hff, 4'h0);
		wr(16'h1c43, 8'hff, 4'h0);
		rd(16'h1c83, 8'h00);
		rd(16'h1c7f, 8'h00);
		rd(16'h1cc0, 8'h00);
		wr(16'h1cbd, 8'h11, 4'h0);
		for (i = 0; i < 4; i++) rd(16'h1cbc + i[15:0], 8'h5a);
		$display("window test done");
		// sticky status, clears, lost events, set against clear
		wr(16'h1c83, 8'h07, 4'h0);
		wr(16'h0000, 8'h00, 4'h5);
		rd(16'h1c84, 8'h05);
		wr(16'h1c84, 8'h01, 4'h0);
		rd(16'h1c84, 8'h04);
		wr(16'h1c84, 8'h00, 4'h0);
		rd(16'h1c84, 8'h04);
		wr(16'h0000, 8'h00, 4'h4);
		rd(16'h1c98, 8'h02);
		rd(16'h1c98, 8'h00);
		wr(16'h1c84, 8'h01, 4'h1);
		rd(16'h1c84, 8'h05);
		wr(16'h0000, 8'h00, 4'h8);
		rd(16'h1c94, 8'h01);
		wr(16'h1c94, 8'h01, 4'h0);
		rd(16'h1c94, 8'h00);
		@(posedge core_clk) gpio_pin <= 8'h20;
		repeat (6) @(posedge core_clk);
		rd(16'h1ca4, 8'h20);
		@(posedge core_clk) gpio_pin <= 8'h00;
		repeat (6) @(posedge core_clk);
		rd(16'h1ca4, 8'h00);
		rd(16'h1ca6, 8'h20);
		$display("status test done");
		// uart level on every line; slot spacing is three periods
		@(posedge core_clk) uart_irq <= 2'h1;
		for (i = 0; i < 8; i++) begin
			wr(16'h1c95, {1'b1, i[2:0], 4'h0}, 4'h0);
			slot(1'b1, 1);
			if (i == 0) base = last_pos - 9;
			check(8'(last_pos), 8'(base + 3 * irq_of[i]));
		end
		@(posedge core_clk) uart_irq <= 2'h0;
		slot(1'b0, 1);
		wr(16'h1c95, 8'h50, 4'h0);
		slot(1'b0, 0);
		wr(16'h1c95, 8'ha0, 4'h0);
		wr(16'h1c97, 8'ha0, 4'h0);
		wr(16'h1ca5, 8'h20, 4'h0);
		slot(1'b1, 1);
		$display("serial irq test done");
		// aux hold keeps the gpio routing through a platform reset
		wr(16'h1c90, 8'h02, 4'h0);
		plat_pulse();
		rd(16'h1c97, 8'ha0);
		rd(16'h1c90, 8'h02);
		rd(16'h1c95, 8'h00);
		rd(16'h1ca6, 8'h00);
		wr(16'h1c90, 8'h00, 4'h0);
		plat_pulse();
		rd(16'h1c97, 8'h00);
		// second uart alone on irq7 after the platform reset cleared the rest
		wr(16'h1c96, 8'hc0, 4'h0);
		@(posedge core_clk) uart_irq <= 2'h2;
		slot(1'b1, 1);
		check(8'(last_pos), 8'(base + 3 * irq_of[4]));
		$display("reset domain test done");
		report_and_stop();
	end
endmodule : tb_lpc_io_window_irq_routing
`default_nettype wire
